// file: src/esm_defs.svh
/*
  Constants for the extended stack and move execution unit: register bus
  offsets, command field codes, status register bit positions, operand masks
  and stack steps.
  Assumes it is included by bare name after the package, never compiled alone.
*/
`ifndef ESM_DEFS_SVH
`define ESM_DEFS_SVH

// Register bus byte offsets
`define ESM_OFF_CMD       8'h00
`define ESM_OFF_SRC       8'h04
`define ESM_OFF_DST       8'h08
`define ESM_OFF_STAT      8'h0C
`define ESM_REGWIN_SEL    2'h1

// Operation codes
`define ESM_OP_DOUBLE_INC 3'h0
`define ESM_OP_INVERT     3'h1
`define ESM_OP_MOVE       3'h2
`define ESM_OP_RST_MULTI  3'h3
`define ESM_OP_SAVE_MULTI 3'h4
`define ESM_OP_RST_ONE    3'h5
`define ESM_OP_SAVE_ONE   3'h6

// Operand sizes
`define ESM_SZ_BYTE       2'h0
`define ESM_SZ_WORD       2'h1
`define ESM_SZ_ADDR       2'h2

// Source operand kinds
`define ESM_SRC_REG       2'h0
`define ESM_SRC_IMM       2'h1
`define ESM_SRC_MEM       2'h2

// Core register indices
`define ESM_IDX_STACK_PTR 4'h1
`define ESM_IDX_STATUS    4'h2

// Status register flag positions
`define ESM_FLAG_C        0
`define ESM_FLAG_Z        1
`define ESM_FLAG_N        2
`define ESM_FLAG_V        8

// Operand masks, steps, high word offset and bus status bits
`define ESM_MASK_BYTE     20'h000FF
`define ESM_MASK_WORD     20'h0FFFF
`define ESM_MASK_ADDR     20'hFFFFF
`define ESM_STEP_SHORT    20'h00002
`define ESM_STEP_LONG     20'h00004
`define ESM_HI_WORD_OFS   20'h00002
`define ESM_STAT_BUSY     0
`define ESM_STAT_DONE     1

`endif

// file: src/esm_pkg.sv
/*
  Types for the extended stack and move execution unit: state machine codes,
  the command word and the data memory request.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package esm_pkg;

  // One-hot sequencer states
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_LOAD  = 8'h02,
    ST_RD_LO = 8'h04,
    ST_RD_HI = 8'h08,
    ST_EXEC  = 8'h10,
    ST_WR_HI = 8'h20,
    ST_WR_LO = 8'h40,
    ST_NEXT  = 8'h80
  } esm_state_e;

  // Command word as written by software, high bits first
  typedef struct packed {
    logic [3:0] cnt_m1;
    logic [3:0] dst_reg;
    logic [3:0] src_reg;
    logic       dst_mem;
    logic [1:0] src_kind;
    logic [1:0] size;
    logic [2:0] op;
  } esm_cmd_s;

  // One data memory word or byte transfer
  typedef struct packed {
    logic        req;
    logic        we;
    logic        byte_sel;
    logic [19:0] addr;
    logic [15:0] wdata;
  } esm_mem_req_s;

endpackage

// file: src/esm_exec_unit.sv
/*
  Execution unit for extended double increment, invert, move and the stack
  save/restore instructions, with its own sixteen 20-bit core registers.
  Assumes an Avalon-MM master for commands and a data memory that answers
  each request with a one-cycle ack; bytes travel in the low lane.
*/
`timescale 1ns/1ps
`include "esm_defs.svh"
`default_nettype none

module esm_exec_unit (
  // Clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_reset,
  // Avalon-MM slave
  input  wire logic [7:0]           i_avs_address,
  input  wire logic                 i_avs_read,
  input  wire logic                 i_avs_write,
  input  wire logic [31:0]          i_avs_writedata,
  input  wire logic [3:0]           i_avs_byteenable,
  output logic      [31:0]          o_avs_readdata,
  output logic                      o_avs_waitrequest,
  // Data memory master
  output var esm_pkg::esm_mem_req_s o_mem_req,
  input  wire logic [15:0]          i_mem_rdata,
  input  wire logic                 i_mem_ack
);

  esm_pkg::esm_state_e   state_q, state_d;
  esm_pkg::esm_cmd_s     cmd_q;
  esm_pkg::esm_mem_req_s mem_q, mem_d;
  logic [19:0] regs_q [16];
  logic [19:0] src_val_q;
  logic [19:0] dst_addr_q;
  logic [19:0] val_q, val_d;
  logic [19:0] res_q, res_d;
  logic [19:0] addr_q, addr_d;
  logic [3:0]  idx_q, idx_d;
  logic [3:0]  left_q, left_d;
  logic        done_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic [31:0] wmask;
  logic        acc_wr;
  logic        start;
  logic        finish;
  logic [19:0] m;
  logic [19:0] half;
  logic [19:0] step;
  logic [19:0] sp_cur;
  logic [19:0] sp_up;
  logic [19:0] sp_dn;
  logic [19:0] ex_res;
  logic [19:0] sr_base;
  logic        fl_we;
  logic        fl_n;
  logic        fl_z;
  logic        fl_c;
  logic        fl_v;
  logic        is_save;
  logic        is_restore;
  logic        dst_style;
  logic        reg_we;
  logic [3:0]  reg_idx;
  logic        mem_wr_need;

  function automatic logic [19:0] size_mask(input logic [1:0] sz);
    logic [19:0] r;
    r = `ESM_MASK_WORD;
    if (sz == `ESM_SZ_BYTE) begin
      r = `ESM_MASK_BYTE;
    end else if (sz == `ESM_SZ_ADDR) begin
      r = `ESM_MASK_ADDR;
    end
    return r;
  endfunction

  // Bus decode; one wait cycle then a one-cycle answer
  assign acc_wr = i_avs_write && !wait_q;
  assign start  = acc_wr && (i_avs_address == `ESM_OFF_CMD) && (state_q == esm_pkg::ST_IDLE);
  assign wmask  = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                   {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (i_avs_address == `ESM_OFF_CMD) begin
      rd_mux = {12'h000, cmd_q};
    end else if (i_avs_address == `ESM_OFF_SRC) begin
      rd_mux = {12'h000, src_val_q};
    end else if (i_avs_address == `ESM_OFF_DST) begin
      rd_mux = {12'h000, dst_addr_q};
    end else if (i_avs_address == `ESM_OFF_STAT) begin
      rd_mux = {30'h0000_0000, done_q, (state_q != esm_pkg::ST_IDLE)};
    end else if (i_avs_address[7:6] == `ESM_REGWIN_SEL) begin
      rd_mux = {12'h000, regs_q[i_avs_address[5:2]]};
    end
  end

  // Bus answer; waitrequest drops for exactly one cycle per request
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if ((i_avs_read || i_avs_write) && wait_q) begin
      wait_q  <= 1'b0;
      rdata_q <= rd_mux;
    end else begin
      wait_q  <= 1'b1;
    end
  end

  // Command and operand registers; writes while busy are dropped
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cmd_q      <= '0;
      src_val_q  <= 20'h00000;
      dst_addr_q <= 20'h00000;
    end else if (acc_wr && (state_q == esm_pkg::ST_IDLE)) begin
      if (i_avs_address == `ESM_OFF_CMD) begin
        cmd_q <= esm_pkg::esm_cmd_s'((i_avs_writedata[19:0] & wmask[19:0]) | (cmd_q & ~wmask[19:0]));
      end
      if (i_avs_address == `ESM_OFF_SRC) begin
        src_val_q <= (i_avs_writedata[19:0] & wmask[19:0]) | (src_val_q & ~wmask[19:0]);
      end
      if (i_avs_address == `ESM_OFF_DST) begin
        dst_addr_q <= (i_avs_writedata[19:0] & wmask[19:0]) | (dst_addr_q & ~wmask[19:0]);
      end
    end
  end

  // Done flag; completion wins over a software clear in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (start) begin
      done_q <= 1'b0;
    end else if (acc_wr && (i_avs_address == `ESM_OFF_STAT) && i_avs_writedata[`ESM_STAT_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // Operation decode shared by sequencer and register file
  assign is_save    = (cmd_q.op == `ESM_OP_SAVE_ONE) || (cmd_q.op == `ESM_OP_SAVE_MULTI);
  assign is_restore = (cmd_q.op == `ESM_OP_RST_ONE) || (cmd_q.op == `ESM_OP_RST_MULTI);
  assign dst_style  = (cmd_q.op == `ESM_OP_DOUBLE_INC) || (cmd_q.op == `ESM_OP_INVERT) ||
                      (cmd_q.op == `ESM_OP_MOVE) || (cmd_q.op == `ESM_OP_RST_ONE);
  assign reg_we      = (dst_style && !cmd_q.dst_mem) || (cmd_q.op == `ESM_OP_RST_MULTI);
  assign reg_idx     = (cmd_q.op == `ESM_OP_RST_MULTI) ? idx_q : cmd_q.dst_reg;
  assign mem_wr_need = (dst_style && cmd_q.dst_mem) || is_save;

  // Stack steps; bytes still move the pointer by two
  // step two or four
  assign step   = (cmd_q.size == `ESM_SZ_ADDR) ? `ESM_STEP_LONG : `ESM_STEP_SHORT;
  assign sp_cur = regs_q[`ESM_IDX_STACK_PTR];
  assign sp_up  = (sp_cur + step) & `ESM_MASK_ADDR;
  assign sp_dn  = (sp_cur - step) & `ESM_MASK_ADDR;
  assign m      = size_mask(cmd_q.size);
  assign half   = m >> 1;

  // Arithmetic and flag results from the loaded operand
  always_comb begin
    ex_res = val_q;
    fl_we  = 1'b0;
    fl_n   = 1'b0;
    fl_z   = 1'b0;
    fl_c   = 1'b0;
    fl_v   = 1'b0;
    if (cmd_q.op == `ESM_OP_DOUBLE_INC) begin
      ex_res = (val_q + `ESM_STEP_SHORT) & m;
      fl_we  = 1'b1;
      fl_c   = (val_q == m) || (val_q == (m - 20'h00001));
      fl_v   = (val_q == half) || (val_q == (half - 20'h00001));
    end else if (cmd_q.op == `ESM_OP_INVERT) begin
      ex_res = val_q ^ m;
      fl_we  = 1'b1;
      fl_z   = (val_q == m);
      fl_c   = !(val_q == m);
      fl_v   = |(val_q & ~half);
    end
    fl_n = |(ex_res & ~half);
    if (cmd_q.op == `ESM_OP_DOUBLE_INC) begin
      fl_z = (ex_res == 20'h00000);
    end
  end

  // Flag merge onto the status register; a register result landing there
  // is the base so its bits outside the flags are not lost
  assign sr_base = (reg_we && (reg_idx == `ESM_IDX_STATUS)) ? ex_res : regs_q[`ESM_IDX_STATUS];

  // Core register file: bus writes while idle, results, pointer and flags
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      for (int i = 0; i < 16; i++) begin
        regs_q[i] <= 20'h00000;
      end
    end else begin
      if (acc_wr && (state_q == esm_pkg::ST_IDLE) && (i_avs_address[7:6] == `ESM_REGWIN_SEL)) begin
        regs_q[i_avs_address[5:2]] <= (i_avs_writedata[19:0] & wmask[19:0]) |
                                      (regs_q[i_avs_address[5:2]] & ~wmask[19:0]);
      end
      if (state_q == esm_pkg::ST_EXEC) begin
        if (is_restore) begin
          regs_q[`ESM_IDX_STACK_PTR] <= sp_up;
        end
        if (is_save) begin
          regs_q[`ESM_IDX_STACK_PTR] <= sp_dn;
        end
        if (reg_we) begin
          regs_q[reg_idx] <= ex_res;
        end
        // only C Z N V change
        if (fl_we) begin
          regs_q[`ESM_IDX_STATUS] <= {sr_base[19:9], fl_v, sr_base[7:3], fl_n, fl_z, fl_c};
        end
      end
    end
  end

  // Sequencer next state and datapath loads
  always_comb begin
    state_d = state_q;
    val_d   = val_q;
    res_d   = res_q;
    addr_d  = addr_q;
    idx_d   = idx_q;
    left_d  = left_q;
    finish  = 1'b0;
    unique case (state_q)
      esm_pkg::ST_IDLE: begin
        if (start) begin
          state_d = esm_pkg::ST_LOAD;
        end
      end
      esm_pkg::ST_LOAD: begin
        left_d  = cmd_q.cnt_m1;
        state_d = esm_pkg::ST_EXEC;
        if ((cmd_q.op == `ESM_OP_DOUBLE_INC) || (cmd_q.op == `ESM_OP_INVERT)) begin
          val_d  = regs_q[cmd_q.dst_reg] & m;
          addr_d = dst_addr_q;
          if (cmd_q.dst_mem) begin
            state_d = esm_pkg::ST_RD_LO;
          end
        end else if ((cmd_q.op == `ESM_OP_MOVE) || (cmd_q.op == `ESM_OP_SAVE_ONE)) begin
          val_d  = ((cmd_q.src_kind == `ESM_SRC_IMM) ? src_val_q : regs_q[cmd_q.src_reg]) & m;
          addr_d = src_val_q;
          if (cmd_q.src_kind == `ESM_SRC_MEM) begin
            state_d = esm_pkg::ST_RD_LO;
          end
        end else if (is_restore) begin
          idx_d   = cmd_q.dst_reg - cmd_q.cnt_m1;
          addr_d  = sp_cur;
          state_d = esm_pkg::ST_RD_LO;
        end else if (cmd_q.op == `ESM_OP_SAVE_MULTI) begin
          idx_d = cmd_q.dst_reg;
          val_d = regs_q[cmd_q.dst_reg] & m;
        end else begin
          // Unused code finishes with no effect
          finish  = 1'b1;
          state_d = esm_pkg::ST_IDLE;
        end
      end
      esm_pkg::ST_RD_LO: begin
        if (i_mem_ack) begin
          val_d   = {4'h0, i_mem_rdata} & m;
          state_d = (cmd_q.size == `ESM_SZ_ADDR) ? esm_pkg::ST_RD_HI : esm_pkg::ST_EXEC;
        end
      end
      esm_pkg::ST_RD_HI: begin
        if (i_mem_ack) begin
          val_d   = {i_mem_rdata[3:0], val_q[15:0]};
          state_d = esm_pkg::ST_EXEC;
        end
      end
      esm_pkg::ST_EXEC: begin
        res_d   = ex_res;
        addr_d  = is_save ? sp_dn : dst_addr_q;
        state_d = esm_pkg::ST_NEXT;
        if (mem_wr_need) begin
          state_d = (cmd_q.size == `ESM_SZ_ADDR) ? esm_pkg::ST_WR_HI : esm_pkg::ST_WR_LO;
        end
      end
      esm_pkg::ST_WR_HI: begin
        if (i_mem_ack) begin
          state_d = esm_pkg::ST_WR_LO;
        end
      end
      esm_pkg::ST_WR_LO: begin
        if (i_mem_ack) begin
          state_d = esm_pkg::ST_NEXT;
        end
      end
      esm_pkg::ST_NEXT: begin
        state_d = esm_pkg::ST_IDLE;
        finish  = 1'b1;
        if ((cmd_q.op == `ESM_OP_RST_MULTI) && (left_q != 4'h0)) begin
          finish  = 1'b0;
          left_d  = left_q - 4'h1;
          idx_d   = idx_q + 4'h1;
          addr_d  = sp_cur;
          state_d = esm_pkg::ST_RD_LO;
        end else if ((cmd_q.op == `ESM_OP_SAVE_MULTI) && (left_q != 4'h0)) begin
          finish  = 1'b0;
          left_d  = left_q - 4'h1;
          idx_d   = idx_q - 4'h1;
          val_d   = regs_q[idx_q - 4'h1] & m;
          state_d = esm_pkg::ST_EXEC;
        end
      end
      default: begin
        state_d = esm_pkg::ST_IDLE;
      end
    endcase
  end

  // Memory request for the state being entered; held until acked
  always_comb begin
    mem_d          = '0;
    mem_d.req      = (state_d == esm_pkg::ST_RD_LO) || (state_d == esm_pkg::ST_RD_HI) ||
                     (state_d == esm_pkg::ST_WR_HI) || (state_d == esm_pkg::ST_WR_LO);
    mem_d.we       = (state_d == esm_pkg::ST_WR_HI) || (state_d == esm_pkg::ST_WR_LO);
    mem_d.byte_sel = (cmd_q.size == `ESM_SZ_BYTE);
    mem_d.addr     = addr_d;
    mem_d.wdata    = res_d[15:0];
    if ((state_d == esm_pkg::ST_RD_HI) || (state_d == esm_pkg::ST_WR_HI)) begin
      mem_d.addr  = (addr_d + `ESM_HI_WORD_OFS) & `ESM_MASK_ADDR;
      mem_d.wdata = {12'h000, res_d[19:16]};
    end
  end

  // Sequencer and datapath registers
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_q <= esm_pkg::ST_IDLE;
      val_q   <= 20'h00000;
      res_q   <= 20'h00000;
      addr_q  <= 20'h00000;
      idx_q   <= 4'h0;
      left_q  <= 4'h0;
      mem_q   <= '0;
    end else begin
      state_q <= state_d;
      val_q   <= val_d;
      res_q   <= res_d;
      addr_q  <= addr_d;
      idx_q   <= idx_d;
      left_q  <= left_d;
      mem_q   <= mem_d;
    end
  end

  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_mem_req         = mem_q;

endmodule

`default_nettype wire

// file: dv/esm_mem_model.sv
/*
  Data memory model for the execution unit: 8 KiB of bytes, one-cycle ack
  after a random wait of zero to three cycles.
  Assumes the unit holds each request until it sees the ack.
*/
`timescale 1ns/1ps
`default_nettype none
module esm_mem_model (
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset,
  // Memory link
  input  wire esm_pkg::esm_mem_req_s i_mem_req,
  output logic      [15:0]           o_mem_rdata,
  output logic                       o_mem_ack
);
  logic   [7:0]  mem [0:8191];
  logic   [1:0]  wait_q;
  logic   [12:0] a;
  integer        seed = 32'hCDA3;
  assign a = i_mem_req.addr[12:0];
  // Plain always so the bench may preload the array; read data toggles
  // outside an ack so stale data can never pass for a valid answer
  always @(posedge i_ref_clk) begin
    o_mem_ack <= 1'b0;
    o_mem_rdata <= ~o_mem_rdata;
    if (i_reset) begin
      wait_q <= 2'h0;
      o_mem_rdata <= 16'h5A5A;
    end else if (i_mem_req.req && !o_mem_ack) begin
      if (wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else begin
        o_mem_ack <= 1'b1;
        wait_q <= 2'($random(seed));
        o_mem_rdata <= {i_mem_req.byte_sel ? ~mem[a] : mem[a + 13'h1], mem[a]};
        if (i_mem_req.we) begin
          mem[a] <= i_mem_req.wdata[7:0];
          if (!i_mem_req.byte_sel) mem[a + 13'h1] <= i_mem_req.wdata[15:8];
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/esm_exec_unit_asserts.sv
/*
  Port checker for the execution unit: bus handshake and memory word order.
  Assumes it is bound to every esm_exec_unit and that commands start idle.
*/
`timescale 1ns/1ps
`default_nettype none
module esm_exec_unit_asserts (
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset,
  // Register bus
  input  wire logic [7:0]            i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  input  wire logic [31:0]           o_avs_readdata,
  input  wire logic                  o_avs_waitrequest,
  // Memory link
  input  wire esm_pkg::esm_mem_req_s o_mem_req,
  input  wire logic [15:0]           i_mem_rdata,
  input  wire logic                  i_mem_ack
);
  logic [2:0]  op_q;
  logic [1:0]  sz_q;
  logic        ph_q, first_q, prev_req_q, prev_ack_q, start, acc, fresh, long;
  logic [19:0] last_q;
  assign start = i_avs_write && !o_avs_waitrequest && i_avs_address == 8'h00;
  assign acc   = o_mem_req.req && i_mem_ack;
  assign fresh = o_mem_req.req && (!prev_req_q || prev_ack_q);
  assign long  = sz_q == 2'h2;
  // Command snoop; pair phase restarts with every command
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      op_q <= 3'h7;
      sz_q <= 2'h0;
      ph_q <= 1'b0;
      first_q <= 1'b1;
    end else if (start) begin
      op_q <= i_avs_writedata[2:0];
      sz_q <= i_avs_writedata[4:3];
      ph_q <= 1'b0;
      first_q <= 1'b1;
    end else if (acc) begin
      ph_q <= ph_q ^ long;
      first_q <= 1'b0;
    end
  end
  // Last completed address and previous handshake state
  always_ff @(posedge i_ref_clk) begin
    if (acc) last_q <= o_mem_req.addr;
    prev_req_q <= o_mem_req.req && !i_reset;
    prev_ack_q <= i_mem_ack;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  bus_answer_a :
    assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus request not answered in one cycle");
  bus_single_a :
    assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("answer stood too long");
  read_top_a :
    assert property (!o_avs_waitrequest && i_avs_read |-> o_avs_readdata[31:20] == 12'h000)
    else $error("read data top bits set");
  mem_hold_a :
    assert property (o_mem_req.req && !i_mem_ack |=> o_mem_req.req && $stable(o_mem_req))
    else $error("memory request changed before ack");
  high_first_a :
    assert property (acc && o_mem_req.we && long && !ph_q |=> o_mem_req.req && o_mem_req.we
      && o_mem_req.addr == last_q - 20'h00002) else $error("low word not written below high word");
  low_then_high_a :
    assert property (acc && !o_mem_req.we && long && !ph_q |=> o_mem_req.req && !o_mem_req.we
      && o_mem_req.addr == last_q + 20'h00002) else $error("high word not read above low word");
  high_bits_a :
    assert property (o_mem_req.req && o_mem_req.we && long && !ph_q |-> o_mem_req.wdata[15:4] == 12'h000)
    else $error("high word carries stray bits");
  save_down_a :
    assert property (fresh && o_mem_req.we && op_q == 3'h4 && !first_q |-> o_mem_req.addr == last_q - 20'h00002)
    else $error("multi save not moving downward");
  restore_up_a :
    assert property (fresh && !o_mem_req.we && op_q == 3'h3 && !first_q |-> o_mem_req.addr == last_q + 20'h00002)
    else $error("multi restore not moving upward");
  cover property (start && i_avs_writedata[2:0] == 3'h3);
  cover property (start && i_avs_writedata[2:0] == 3'h4 && i_avs_writedata[4:3] == 2'h2);
  cover property (start && i_avs_writedata[2:0] == 3'h6 && i_avs_writedata[4:3] == 2'h0);
endmodule
bind esm_exec_unit esm_exec_unit_asserts esm_exec_unit_asserts_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_mem_req(o_mem_req), .i_mem_rdata(i_mem_rdata), .i_mem_ack(i_mem_ack));
`default_nettype wire

// file: dv/extended_stack_move_ops_tb.sv
/*
  Testbench for the execution unit: every operation with random operands, in
  every size except byte for the multi save and restore, checked against a
  reference model of registers and memory.
  Assumes the memory model and the bound port checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module extended_stack_move_ops_tb;
  logic                  clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, ack, wait_r;
  logic [7:0]            adr = 8'h00;
  logic [3:0]            be = 4'hF;
  logic [31:0]           wd = 32'h0, rdat;
  logic [15:0]           mrd;
  esm_pkg::esm_mem_req_s mreq;
  logic [19:0]           rm [16];
  logic [7:0]            em [0:8191];
  integer                seed = 32'hCDA3, fails = 0, check_count = 0;
  always #4 clk = ~clk;
  esm_exec_unit esm_exec_unit_i (.i_ref_clk(clk), .i_reset(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wait_r), .o_mem_req(mreq), .i_mem_rdata(mrd), .i_mem_ack(ack));
  esm_mem_model esm_mem_model_i (.i_ref_clk(clk), .i_reset(rst), .i_mem_req(mreq), .o_mem_rdata(mrd),
    .o_mem_ack(ack));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction
  // One bus access; holds the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wait_r !== 1'b0) @(posedge clk);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  function automatic logic [19:0] ld(input int a, input logic [1:0] s);
    if (s == 2'h0) return {12'h0, em[a]};
    if (s == 2'h1) return {4'h0, em[a + 1], em[a]};
    return {em[a + 2][3:0], em[a + 1], em[a]};
  endfunction
  task automatic st(input int a, input logic [19:0] v, input logic [1:0] s);
    em[a] = v[7:0];
    if (s != 2'h0) em[a + 1] = v[15:8];
    if (s == 2'h2) begin
      em[a + 2] = {4'h0, v[19:16]};
      em[a + 3] = 8'h00;
    end
  endtask
  // negative and zero, with carry and overflow given
  task automatic fl(input logic [19:0] v, input logic [19:0] m, input logic c, input logic ov);
    rm[2] = (rm[2] & ~20'h00107) | {11'h0, ov, 5'h0, |(v & ~(m >> 1)), v == 20'h0, c};
  endtask
  // Compare all core registers and the whole memory image
  task automatic cmp();
    logic [31:0] q;
    for (int k = 0; k < 16; k++) begin
      bus(1'b0, 8'h40 + 8'(4 * k), 32'h0, q);
      chk($sformatf("R%0d", k), q, {12'h0, rm[k]}); // registers
    end
    for (int k = 0; k < 8192; k++) chk("mem", esm_mem_model_i.mem[k], em[k]); // whole memory image
  endtask
  task automatic step(input int it);
    logic [2:0]  op;
    logic [1:0]  sz, sk;
    logic        dm;
    logic [19:0] m, v, sv, src, dst;
    logic [31:0] q;
    int          s, d, n, sp, stp, sa, da, k;
    op = 3'(it % 7);
    sz = 2'((it / 7) % 3);
    if (op == 3'h3 || op == 3'h4) sz = 2'h1 + {1'b0, sz[0]};
    sk = 2'(rnd(3));
    dm = rnd(2) == 1;
    d = (op == 3'h3 || op == 3'h4) ? 4 + rnd(12) : 3 + rnd(13);
    n = (op == 3'h3 || op == 3'h4) ? 1 + rnd(d - 1) : 1;
    s = 3 + rnd(13);
    sa = 2 * rnd(2048);
    da = 2 * rnd(2048) + (sz == 2'h0 ? rnd(2) : 0);
    sv = 20'(rnd(1048576));
    m = (sz == 2'h0) ? 20'h000FF : (sz == 2'h1 ? 20'h0FFFF : 20'hFFFFF);
    for (k = 0; k < 16; k++) rm[k] = 20'(rnd(1048576));
    rm[1] = 20'h01800 + 20'(2 * rnd(256));
    k = rnd(4);
    if (op < 3'h2 && k < 3) rm[d] = (k == 0) ? (m >> 1) - 20'h1 : (k == 1 ? m >> 1 : m);
    for (k = 0; k < 16; k++) bus(1'b1, 8'h40 + 8'(4 * k), {12'h0, rm[k]}, q);
    bus(1'b1, 8'h04, (sk == 2'h1) ? {12'h0, sv} : 32'(sa), q);
    bus(1'b1, 8'h08, 32'(da), q);
    src = (sk == 2'h0) ? rm[s] & m : (sk == 2'h1 ? sv & m : ld(sa, sz));
    dst = dm ? ld(da, sz) : rm[d] & m;
    stp = (sz == 2'h2) ? 4 : 2;
    sp = rm[1];
    v = 20'h0;
    case (op)
      3'h0: begin
        v = (dst + 20'h2) & m;
        fl(v, m, dst == m - 20'h1 || dst == m, dst == (m >> 1) - 20'h1 || dst == (m >> 1));
      end
      3'h1: begin
        v = ~dst & m;
        fl(v, m, v != 20'h0, |(dst & ~(m >> 1)));
      end
      3'h2: v = src;
      3'h3: for (k = 0; k < n; k++) begin
        rm[(d - n + 1 + k) & 15] = ld(sp, sz);
        sp += stp;
      end
      3'h4: for (k = 0; k < n; k++) begin
        sp -= stp;
        st(sp, rm[(d - k) & 15], sz);
      end
      3'h5: begin
        v = ld(sp, sz);
        sp += stp;
      end
      default: begin
        sp -= stp;
        st(sp, src, sz);
      end
    endcase
    rm[1] = 20'(sp);
    if (op < 3'h3 || op == 3'h5) begin
      if (dm) st(da, v, sz);
      else rm[d] = v;
    end
    bus(1'b1, 8'h00, {12'h0, 4'(n - 1), 4'(d), 4'(s), dm, sk, sz, op}, q);
    k = 0;
    do begin
      bus(1'b0, 8'h0C, 32'h0, q);
      k++;
    end while (q[1] !== 1'b1 && k < 300);
    chk("done", q, 32'h2);
    cmp();
  endtask
  initial begin
    logic [31:0] q;
    for (int k = 0; k < 8192; k++) begin
      em[k] = 8'(rnd(256));
      esm_mem_model_i.mem[k] = em[k];
    end
    for (int k = 0; k < 16; k++) rm[k] = 20'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cmp();
    bus(1'b1, 8'h30, 32'hFFFFFFFF, q);
    bus(1'b0, 8'h30, 32'h0, q);
    chk("unmapped", q, 32'h0);
    for (int it = 0; it < 63; it++) step(it);
    // Unused operation code only raises done, nothing else moves
    bus(1'b1, 8'h00, 32'h00000007, q);
    bus(1'b0, 8'h0C, 32'h0, q);
    chk("noop done", q, 32'h2);
    cmp();
    bus(1'b1, 8'h0C, 32'h2, q);
    bus(1'b0, 8'h0C, 32'h0, q);
    chk("done clear", q, 32'h0);
    // Reset while idle clears the register file but keeps the memory
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 16; k++) rm[k] = 20'h0;
    cmp();
    // Only the enabled byte lane replaces the old register bits
    bus(1'b1, 8'h54, 32'hFFFFFFFF, q);
    be <= 4'h2;
    bus(1'b1, 8'h54, 32'h0, q);
    be <= 4'hF;
    bus(1'b0, 8'h54, 32'h0, q);
    chk("lane merge", q, 32'h000F00FF);
    test_done();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
